// ==== design/dqsp_defines.vh ====
// Constants for the dual-quad serial clock phasing front end
// Function
// - Host uses clock mode 0 or 3
// - Single rate: sample inputs on rising edges
// - Single rate: output valid from falling edges
// - A cycle runs falling edge to falling edge
// - Mode 0 first cycle starts at select fall
// - Double rate works in modes 0 and 3
// - Double rate instruction sampled on rising only
// - Double rate address, data sampled both edges
// - First address bit on rising after instruction
// - Double rate read drives after last dummy
// - Instruction lanes 0/4, nibbles repeated, bytes
// - Deselected: ignore inputs, outputs high impedance
// - Double rate output changes every clock edge
`ifndef DQSP_DEFINES_VH
`define DQSP_DEFINES_VH

// Serial link facts
`define DQSP_LANES 8
`define DQSP_INST_CYCLES 4'h8
`define DQSP_INST_LAST 4'h7
`define DQSP_LINK_PERIOD_NS 80

// Receive stream word: tag then byte
`define DQSP_TAG_INST 2'h1
`define DQSP_TAG_ADDR 2'h2
`define DQSP_TAG_DATA 2'h3
`define DQSP_WORD_W 10
`define DQSP_FIFO_DEPTH 8
`define DQSP_FIFO_CNT_W 4

// Reset and read fill values
`define DQSP_RST_BYTE 8'h00
`define DQSP_IDLE_FILL 8'hff

`endif

// ==== design/dqsp_front.v ====
// Dual-quad serial target clock phasing front end and receive FIFO
`timescale 1ns/1ps
`include "dqsp_defines.vh"

// Shift-register FIFO with registered head, valid and ready
module dqsp_fifo #(
  parameter WIDTH = `DQSP_WORD_W,
  parameter DEPTH = `DQSP_FIFO_DEPTH,
  parameter CNT_W = `DQSP_FIFO_CNT_W
) (
  input wire i_clk,               // System clock
  input wire i_rst_n,             // Async reset, active low
  input wire i_valid,             // Push request
  input wire [WIDTH-1:0] i_data,  // Push word
  output reg o_ready,             // Room for a push
  output reg o_valid,             // Head word present
  output wire [WIDTH-1:0] o_data, // Head word
  input wire i_ready              // Pop request
);
  wire [WIDTH-1:0] mem_w [0:DEPTH-1];
  reg [CNT_W-1:0] cnt_q;
  wire push;
  wire pop;
  wire [CNT_W-1:0] cnt_d;
  wire [CNT_W-1:0] wr_idx;
  wire [DEPTH-1:0] wr_sel;

  // Handshakes and occupancy
  assign push = i_valid && o_ready;
  assign pop = i_ready && o_valid;
  assign cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, push}
    - {{(CNT_W-1){1'b0}}, pop};
  assign wr_idx = pop ? cnt_q - {{(CNT_W-1){1'b0}}, 1'b1} : cnt_q;
  // One-hot write select keeps index math out of the entries
  assign wr_sel = {{(DEPTH-1){1'b0}}, push} << wr_idx;
  assign o_data = mem_w[0];

  // Flags registered from the next count
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= {CNT_W{1'b0}};
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_ready <= (cnt_d != DEPTH[CNT_W-1:0]);
      o_valid <= (cnt_d != {CNT_W{1'b0}});
    end
  end

  // Each entry shifts down on pop, loads on push
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      reg [WIDTH-1:0] ent_q;
      assign mem_w[g] = ent_q;
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ent_q <= {WIDTH{1'b0}};
        end else if (wr_sel[g]) begin
          ent_q <= i_data;
        end else if (pop && (g < DEPTH - 1)) begin
          ent_q <= mem_w[(g < DEPTH - 1) ? g + 1 : g];
        end
      end
    end
  endgenerate
endmodule

module dqsp_front (
  input wire i_clk,                 // 200 MHz system clock
  input wire i_rst_n,               // Async reset, active low
  input wire i_select_in_a_n,       // Select pin, slice a, low
  input wire i_select_in_b_n,       // Select pin, slice b, low
  input wire i_serial_clk_in_a,     // Serial clock pin, slice a
  input wire i_serial_clk_in_b,     // Serial clock pin, slice b
  input wire [7:0] i_data_lanes,    // Lane pin levels in
  output reg [7:0] o_data_lanes,    // Lane drive values
  output reg [7:0] o_data_lanes_oe, // Lane drive enables
  input wire i_ddr,                 // Next command double rate
  input wire i_read,                // Next command reads data
  input wire [3:0] i_addr_cycles,   // Address cycles
  input wire [4:0] i_dummy_cycles,  // Latency cycles
  input wire [7:0] i_rd_data,       // Read byte to send
  input wire i_rd_valid,            // Read byte present
  output reg o_rd_ready,            // Read byte taken, pulse
  output wire o_rx_valid,           // Received word present
  output wire [9:0] o_rx_word,      // Tag and received byte
  input wire i_rx_ready,            // Received word taken
  output reg o_overrun,             // Word lost, FIFO full
  output reg o_mismatch,            // Slices out of lockstep
  output reg o_mode3,               // Clock high at select
  output reg [4:0] o_phase          // One-hot phase
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_INST = 5'h02;
  localparam [4:0] ST_ADDR = 5'h04;
  localparam [4:0] ST_DUMMY = 5'h08;
  localparam [4:0] ST_DATA = 5'h10;

  // Phase that follows the address stage
  function [4:0] after_addr;
    input [4:0] dummy;
    begin
      after_addr = (dummy != 5'h00) ? ST_DUMMY : ST_DATA;
    end
  endfunction

  // Phase that follows the instruction stage
  function [4:0] after_inst;
    input [3:0] acyc;
    input [4:0] dummy;
    begin
      after_inst = (acyc != 4'h0) ? ST_ADDR : after_addr(dummy);
    end
  endfunction

  reg [1:0] sel_a_q;
  reg [1:0] sel_b_q;
  reg [1:0] sck_a_q;
  reg [1:0] sck_b_q;
  reg [7:0] lane_s1_q;
  reg [7:0] lane_s2_q;
  reg sck_prev_q;
  reg sel_prev_q;
  reg skip_q;
  reg ddr_q;
  reg read_q;
  reg [3:0] acyc_q;
  reg [4:0] dcyc_q;
  reg [4:0] cnt_q;
  reg [7:0] inst_q;
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg push_d;
  reg [9:0] word_d;
  reg launch_d;
  wire fifo_ready;
  wire sck_now;
  wire selected;
  wire rise;
  wire fall;
  wire cyc_end;
  wire sel_fall;

  // Two-flop synchronisers for every pin input
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_a_q <= 2'h3;
      sel_b_q <= 2'h3;
      sck_a_q <= 2'h0;
      sck_b_q <= 2'h0;
      lane_s1_q <= `DQSP_RST_BYTE;
      lane_s2_q <= `DQSP_RST_BYTE;
    end else begin
      sel_a_q <= {sel_a_q[0], i_select_in_a_n};
      sel_b_q <= {sel_b_q[0], i_select_in_b_n};
      sck_a_q <= {sck_a_q[0], i_serial_clk_in_a};
      sck_b_q <= {sck_b_q[0], i_serial_clk_in_b};
      lane_s1_q <= i_data_lanes;
      lane_s2_q <= lane_s1_q;
    end
  end

  // Slices share one select and one clock
  assign selected = !sel_a_q[1] && !sel_b_q[1];
  assign sck_now = sck_a_q[1];
  assign sel_fall = selected && sel_prev_q;
  assign rise = selected && !sel_fall && sck_now && !sck_prev_q;
  assign fall = selected && !sel_fall && !sck_now && sck_prev_q;
  // Mode 3 first fall opens cycle one, it closes none
  assign cyc_end = fall && !skip_q;

  // Edge history, mode capture and command setup
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
      skip_q <= 1'b0;
      o_mode3 <= 1'b0;
      ddr_q <= 1'b0;
      read_q <= 1'b0;
      acyc_q <= 4'h0;
      dcyc_q <= 5'h00;
      o_mismatch <= 1'b0;
    end else begin
      sck_prev_q <= sck_now;
      sel_prev_q <= !selected;
      if (sel_fall) begin
        o_mode3 <= sck_now;
        skip_q <= sck_now;
        ddr_q <= i_ddr;
        read_q <= i_read;
        acyc_q <= i_addr_cycles;
        dcyc_q <= i_dummy_cycles;
      end else if (fall) begin
        skip_q <= 1'b0;
      end
      // Sticky flag when the paired pins disagree
      if ((sel_a_q[1] != sel_b_q[1]) || (sck_a_q[1] != sck_b_q[1])) begin
        o_mismatch <= 1'b1;
      end
    end
  end

  // Phase sequencing and receive stream words
  always @* begin
    state_d = state_q;
    push_d = 1'b0;
    word_d = {`DQSP_TAG_DATA, lane_s2_q};
    launch_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (sel_fall) begin
          state_d = ST_INST;
        end
      end
      ST_INST: begin
        if (cyc_end && cnt_q[3:0] == `DQSP_INST_LAST) begin
          push_d = 1'b1;
          word_d = {`DQSP_TAG_INST, inst_q};
          state_d = after_inst(acyc_q, dcyc_q);
          launch_d = (after_inst(acyc_q, dcyc_q) == ST_DATA) && read_q;
        end
      end
      ST_ADDR: begin
        // Nibble repeated on both slices, kept as one byte
        if (rise || (ddr_q && fall)) begin
          push_d = 1'b1;
          word_d = {`DQSP_TAG_ADDR, lane_s2_q};
        end
        if (cyc_end && cnt_q[3:0] == acyc_q - 4'h1) begin
          state_d = after_addr(dcyc_q);
          launch_d = (after_addr(dcyc_q) == ST_DATA) && read_q;
        end
      end
      ST_DUMMY: begin
        if (cyc_end && cnt_q == dcyc_q - 5'h01) begin
          state_d = ST_DATA;
          launch_d = read_q;
        end
      end
      ST_DATA: begin
        if (read_q) begin
          launch_d = fall || (ddr_q && rise);
        end else if (rise || (ddr_q && fall)) begin
          push_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!selected) begin
      state_d = ST_IDLE;
      push_d = 1'b0;
      launch_d = 1'b0;
    end
  end

  // State, cycle count and instruction shifter
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      inst_q <= `DQSP_RST_BYTE;
      o_phase <= ST_IDLE;
    end else begin
      state_q <= state_d;
      o_phase <= state_d;
      if (state_d != state_q) begin
        cnt_q <= 5'h00;
      end else if (cyc_end) begin
        cnt_q <= cnt_q + 5'h01;
      end
      // Instruction serial on lane 0, lane 4 mirrors it
      if (state_q == ST_INST && rise) begin
        inst_q <= {inst_q[6:0], lane_s2_q[0]};
      end
    end
  end

  // Output launch and lane drive enables
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_lanes <= `DQSP_RST_BYTE;
      o_data_lanes_oe <= 8'h00;
      o_rd_ready <= 1'b0;
    end else begin
      o_rd_ready <= launch_d && i_rd_valid;
      if (!selected) begin
        o_data_lanes_oe <= 8'h00;
      end else if (launch_d) begin
        o_data_lanes_oe <= 8'hff;
      end
      if (launch_d) begin
        o_data_lanes <= i_rd_valid ? i_rd_data : `DQSP_IDLE_FILL;
      end
    end
  end

  // Sticky loss flag when the stream cannot take a word
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overrun <= 1'b0;
    end else if (push_d && !fifo_ready) begin
      o_overrun <= 1'b1;
    end
  end

  dqsp_fifo #(
    .WIDTH(`DQSP_WORD_W),
    .DEPTH(`DQSP_FIFO_DEPTH),
    .CNT_W(`DQSP_FIFO_CNT_W)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(push_d),
    .i_data(word_d),
    .o_ready(fifo_ready),
    .o_valid(o_rx_valid),
    .o_data(o_rx_word),
    .i_ready(i_rx_ready)
  );
endmodule

// ==== sim/dqsp_front_bench.sv ====
// Bench: host model against the phasing front end
`timescale 1ns/1ps
module dqsp_front_bench;
  logic clk, rst_n, skew, ddr, rd, rdy, rd_vld;
  logic [3:0] acyc;
  logic [4:0] dcyc;
  logic [7:0] rd_data, h_lanes;
  logic [9:0] exp_q[$], got_q[$];
  logic [7:0] exp_rd[$];
  int n_mismatch, n_tests;
  wire h_sel_n, h_sck, h_oe, rx_valid, rd_ready, ovr, mis, m3f;
  wire [7:0] d_lanes, d_oe;
  wire [9:0] rx_word;
  wire [4:0] phase;
  wire [7:0] lanes = h_oe ? h_lanes : (d_oe[0] ? d_lanes : h_lanes);
  dqsp_host_model host (.i_clk(clk), .i_lanes(lanes), .o_sel_n(h_sel_n),
    .o_sck(h_sck), .o_lanes(h_lanes), .o_oe(h_oe));
  dqsp_front dut (.i_clk(clk), .i_rst_n(rst_n), .i_select_in_a_n(h_sel_n),
    .i_select_in_b_n(h_sel_n), .i_serial_clk_in_a(h_sck),
    .i_serial_clk_in_b(h_sck ^ skew), .i_data_lanes(lanes),
    .o_data_lanes(d_lanes), .o_data_lanes_oe(d_oe), .i_ddr(ddr),
    .i_read(rd), .i_addr_cycles(acyc), .i_dummy_cycles(dcyc),
    .i_rd_data(rd_data), .i_rd_valid(rd_vld), .o_rd_ready(rd_ready),
    .o_rx_valid(rx_valid), .o_rx_word(rx_word), .i_rx_ready(rdy),
    .o_overrun(ovr), .o_mismatch(mis), .o_mode3(m3f), .o_phase(phase));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Collect popped words; next read byte on each take, first when idle
  always @(posedge clk) begin
    if (rx_valid && rdy) got_q.push_back(rx_word);
    if (h_sel_n) rd_data <= 8'ha5;
    else if (rd_ready) rd_data <= rd_data + 8'h11;
  end
  task check(input string nm, input logic [9:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task test_done();
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // One command with expected words and bytes built alongside
  task frame(input logic m3, dr, r, input logic [7:0] ins,
    input logic [3:0] na, input logic [4:0] nd, nw);
    logic [7:0] vr, vf;
    ddr <= dr;
    rd <= r;
    acyc <= na;
    dcyc <= nd;
    host.open(m3);
    exp_q.push_back({2'h1, ins});
    for (int i = 7; i >= 0; i--)
      host.cyc({2{3'h0, ins[i]}}, ~{2{3'h0, ins[i]}}, 1'b0, dr);
    check("mode", {9'h0, m3}, {9'h0, m3f});
    for (int i = 0; i < na; i++) begin
      vr = {2{4'h1 + i[3:0]}};
      vf = {2{4'h9 + i[3:0]}};
      host.cyc(vr, vf, 1'b0, dr);
      exp_q.push_back({2'h2, vr});
      if (dr) exp_q.push_back({2'h2, vf});
    end
    repeat (nd) host.cyc(8'h00, 8'hff, 1'b0, dr);
    for (int i = 0; i < nw; i++) begin
      vr = 8'h40 + i[7:0];
      vf = 8'h80 + i[7:0];
      host.cyc(vr, vf, r, dr);
      if (!r) exp_q.push_back({2'h3, vr});
      if (!r && dr) exp_q.push_back({2'h3, vf});
    end
    for (int k = 0; k < (r ? (dr ? 2 * nw : nw) : 0); k++)
      exp_rd.push_back(rd_vld ? 8'ha5 + 8'h11 * k[7:0] : 8'hff);
    host.close();
    repeat (6) @(posedge clk);
    check("lane enable", 10'h0, {2'h0, d_oe});
    check("phase", 10'h1, {5'h0, phase});
  endtask
  // Compare the first n words and every byte read
  task judge(input int n);
    int t;
    t = 0;
    while (got_q.size() < n && t < 200) begin
      @(posedge clk);
      t++;
    end
    if (got_q.size() < n) begin
      n_mismatch++;
      test_done();
    end
    check("rx count", 10'(n), 10'(got_q.size()));
    for (int i = 0; i < n; i++) check("rx word", exp_q[i], got_q[i]);
    check("reads", 10'(exp_rd.size()), 10'(host.rd_q.size()));
    while (exp_rd.size() > 0)
      check("read", exp_rd.pop_front(), host.rd_q.pop_front());
    exp_q.delete();
    got_q.delete();
    host.rd_q.delete();
  endtask
  task t_sdr_write();
    frame(1'b0, 1'b0, 1'b0, 8'hc3, 4'h2, 5'h0, 5'h3);
    judge(6);
  endtask
  task t_ddr_write();
    frame(1'b1, 1'b1, 1'b0, 8'h5a, 4'h2, 5'h1, 5'h2);
    judge(9);
  endtask
  task t_sdr_read();
    frame(1'b1, 1'b0, 1'b1, 8'h0b, 4'h1, 5'h2, 5'h3);
    judge(2);
  endtask
  task t_ddr_read();
    frame(1'b0, 1'b1, 1'b1, 8'hed, 4'h2, 5'h3, 5'h2);
    judge(5);
  endtask
  // No read byte on offer, no address or dummy: filler sent
  task t_no_byte();
    rd_vld <= 1'b0;
    frame(1'b0, 1'b0, 1'b1, 8'h6b, 4'h0, 5'h0, 5'h2);
    judge(1);
    rd_vld <= 1'b1;
  endtask
  // FIFO full: later words dropped and flagged
  task t_overrun();
    rdy <= 1'b0;
    frame(1'b0, 1'b0, 1'b0, 8'h02, 4'h4, 5'h0, 5'h6);
    check("overrun", 10'h1, {9'h0, ovr});
    rdy <= 1'b1;
    judge(8);
  endtask
  // Slices out of step, then reset in mid-run clears flags
  task t_mismatch();
    skew <= 1'b1;
    repeat (8) @(posedge clk);
    check("mismatch", 10'h1, {9'h0, mis});
    skew <= 1'b0;
    do_reset();
    check("mismatch", 10'h0, {9'h0, mis});
    check("overrun", 10'h0, {9'h0, ovr});
  endtask
  initial begin
    rst_n = 1'b0;
    skew = 1'b0;
    ddr = 1'b0;
    rd = 1'b0;
    rdy = 1'b1;
    acyc = 4'h0;
    dcyc = 5'h0;
    rd_vld = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    do_reset();
    t_sdr_write();
    t_ddr_write();
    t_sdr_read();
    t_ddr_read();
    t_no_byte();
    t_overrun();
    t_mismatch();
    test_done();
  end
endmodule

// ==== sim/dqsp_front_sva.sv ====
// Checker for the phasing front end, bound to its ports
`timescale 1ns/1ps
module dqsp_front_sva (
  input wire i_clk, // Clock
  input wire i_rst_n, // Reset
  input wire i_select_in_a_n, // Select a
  input wire i_select_in_b_n, // Select b
  input wire i_serial_clk_in_a, // Clock a
  input wire i_ddr, // Double rate
  input wire i_read, // Read
  input wire i_rx_ready, // Pop
  input wire [7:0] o_data_lanes, // Lanes
  input wire [7:0] o_data_lanes_oe, // Enables
  input wire o_rd_ready, // Byte taken
  input wire o_rx_valid, // Word present
  input wire [9:0] o_rx_word, // Word
  input wire o_mismatch, // Lockstep flag
  input wire [4:0] o_phase // Phase
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Deselected long enough to pass the synchronisers
  sequence s_idle;
    (i_select_in_a_n && i_select_in_b_n)[*6];
  endsequence
  // Single rate rise while selected and driving
  sequence s_rise;
    $rose(i_serial_clk_in_a) && !i_ddr && !i_select_in_a_n
      && o_data_lanes_oe[0];
  endsequence
  a_oe_uniform: assert property (
    o_data_lanes_oe == 8'h00 || o_data_lanes_oe == 8'hff)
    else $error("lane enables split");
  a_idle_quiet: assert property (
    s_idle |-> o_data_lanes_oe == 8'h00 && o_phase == 5'h01)
    else $error("driving while deselected");
  a_sdr_hold: assert property (
    s_rise |=> $stable(o_data_lanes)[*6])
    else $error("lanes changed after a rise");
  a_oe_data: assert property (
    $rose(o_data_lanes_oe[0]) |-> o_phase == 5'h10 && i_read)
    else $error("drive began outside read data");
  a_phase_hot: assert property (
    $onehot(o_phase))
    else $error("phase not one-hot");
  a_mis_sticky: assert property (
    o_mismatch |=> o_mismatch)
    else $error("lockstep flag dropped");
  a_take_pulse: assert property (
    o_rd_ready |=> !o_rd_ready)
    else $error("take pulse too long");
  a_rx_stand: assert property (
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_word))
    else $error("word lost before pop");
endmodule

bind dqsp_front dqsp_front_sva u_sva (.*);

// ==== sim/dqsp_host_model.sv ====
// Host controller model: one select, one clock
`timescale 1ns/1ps
module dqsp_host_model (
  input wire i_clk, // System clock
  input wire [7:0] i_lanes, // Lane levels
  output reg o_sel_n, // Shared select
  output reg o_sck, // Shared clock
  output reg [7:0] o_lanes, // Lane drive
  output reg o_oe // Lane enable
);
  logic [7:0] rd_q[$];
  logic m3_q;
  // Deselected and parked at start
  initial begin
    o_sel_n = 1'b1;
    o_sck = 1'b0;
    o_lanes = 8'h00;
    o_oe = 1'b1;
    m3_q = 1'b0;
  end
  // Quarter of the 80 ns link period
  task qtr();
    repeat (4) @(posedge i_clk);
  endtask
  // Park clock, select, opening fall in mode 3
  task open(input logic m3);
    m3_q = m3;
    o_sck <= m3;
    qtr();
    o_sel_n <= 1'b0;
    qtr();
    if (m3) begin
      o_sck <= 1'b0;
      qtr();
    end
  endtask
  // One cycle, rise then fall; released lanes toggle
  task cyc(input logic [7:0] vr, vf, input logic rd, ddr);
    o_oe <= !rd;
    o_lanes <= rd ? ~o_lanes : vr;
    qtr();
    if (rd) rd_q.push_back(i_lanes);
    o_sck <= 1'b1;
    qtr();
    o_lanes <= rd ? ~o_lanes : vf;
    qtr();
    if (rd && ddr) rd_q.push_back(i_lanes);
    o_sck <= 1'b0;
    qtr();
  endtask
  // Deselect, then park the clock
  task close();
    o_oe <= 1'b1;
    o_sel_n <= 1'b1;
    qtr();
    o_sck <= m3_q;
    qtr();
  endtask
endmodule
